/* adc_seq_pkg.sv */
// Constants, register layouts and timing figures of the conversion sequencer.
package adc_seq_pkg;

   localparam int CLK_MHZ = 40;

   // Register byte offsets on the Wishbone bus, one aligned word each.
   localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
   localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
   localparam logic [7:0] OFF_CONFIG = 8'h08;
   localparam logic [7:0] OFF_CMP_HIGH = 8'h0c;
   localparam logic [7:0] OFF_CMP_LOW = 8'h10;
   localparam logic [7:0] OFF_RES_HIGH = 8'h14;
   localparam logic [7:0] OFF_RES_LOW = 8'h18;

   typedef struct packed {
      logic conversionDoneFlag;
      logic doneIrqEnable;
      logic continuousEnable;
      logic [4:0] channelSelect;
   } ctrl_one_t;

   typedef struct packed {
      logic active;
      logic triggerSelect;
      logic compareEnable;
      logic compareGreaterSelect;
      logic [3:0] reserved;
   } ctrl_two_t;

   typedef struct packed {
      logic lowPowerConfig;
      logic [1:0] clockDivider;
      logic longSampleSelect;
      logic [1:0] mode;
      logic [1:0] inputClockSelect;
   } conv_cfg_t;

   typedef struct packed {
      logic [4:0] channel;
      logic sampleEnable;
      logic asyncClockEnable;
      logic lowPower;
   } analog_ctrl_t;

   localparam logic [1:0] MODE_8BIT = 2'h0;
   localparam logic [1:0] MODE_12BIT = 2'h1;
   localparam logic [1:0] MODE_10BIT = 2'h2;

   localparam logic [1:0] CLK_BUS = 2'h0;
   localparam logic [1:0] CLK_BUS_HALF = 2'h1;
   localparam logic [1:0] CLK_ALT = 2'h2;
   localparam logic [1:0] CLK_ASYNC = 2'h3;

   localparam logic [4:0] CHANNEL_OFF = 5'h1f;
   localparam ctrl_one_t CTRL_ONE_RESET = 8'h1f;
   localparam ctrl_two_t CTRL_TWO_RESET = 8'h00;
   localparam conv_cfg_t CONFIG_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Sample phase, in half conversion-clock cycles, rounded up to whole ticks.
   localparam int SAMPLE_SHORT_HALVES = 7;
   localparam int SAMPLE_LONG_HALVES = 47;
   localparam logic [4:0] SAMPLE_SHORT_TICKS = 5'((SAMPLE_SHORT_HALVES + 1) / 2);
   localparam logic [4:0] SAMPLE_LONG_TICKS = 5'((SAMPLE_LONG_HALVES + 1) / 2);
   localparam logic [4:0] FIRST_EXTRA_TICKS = 5'h03;
   localparam logic [4:0] APPROX_8BIT_TICKS = 5'h0d;
   localparam logic [4:0] APPROX_WIDE_TICKS = 5'h10;

   localparam int START_BUS_CYCLES = 5;
   localparam int ASYNC_STARTUP_NS = 5000;
   localparam int ASYNC_STARTUP_CYCLES = (ASYNC_STARTUP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] SETUP_SYNC_LAST = 8'(START_BUS_CYCLES - 1);
   localparam logic [7:0] SETUP_ASYNC_LAST = 8'(START_BUS_CYCLES + ASYNC_STARTUP_CYCLES - 1);

   // The internal asynchronous clock is modelled as the bus clock divided by two.
   localparam logic [1:0] ASYNC_DIV_LAST = 2'h1;

   localparam logic [11:0] MASK_8BIT = 12'h0ff;
   localparam logic [11:0] MASK_10BIT = 12'h3ff;
   localparam logic [11:0] MASK_12BIT = 12'hfff;

endpackage

/* adc_conversion_sequencer.sv */
// Conversion sequencer of a successive-approximation converter with a Wishbone slave.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps

module adc_conversion_sequencer (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic hwTriggerInput,
   input wire logic altClockTick,
   input wire logic [11:0] approxResult,
   input wire logic stopMode,
   input wire logic waitMode,
   output adc_seq_pkg::analog_ctrl_t analogCtrl,
   output logic doneIrq
);
   import adc_seq_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_SAMPLE, ST_APPROX, ST_TRANSFER} state_t;

   state_t state;
   ctrl_one_t ctrlOne;
   ctrl_two_t ctrlTwo;
   conv_cfg_t convCfg;
   logic [7:0] cmpHigh;
   logic [7:0] cmpLow;
   logic [7:0] resultHigh;
   logic [7:0] resultLow;
   logic ackReg;
   logic [31:0] readData;
   logic readHighPending;
   logic hwPrev;
   logic firstConv;
   logic [7:0] busCnt;
   logic [4:0] tickCnt;
   logic halfPhase;
   logic [1:0] asyncCnt;
   logic [2:0] divCnt;

   logic busTake;
   logic busWrite;
   logic busRead;
   logic wrCtrlOne;
   logic wrModeChange;
   logic rdResHigh;
   logic rdResLow;
   logic stopAbort;
   logic abortAny;
   logic hwEdge;
   logic hwStart;
   logic swStart;
   logic srcTick;
   logic adckTick;
   logic [2:0] divLast;
   logic [4:0] sampleLast;
   logic [4:0] approxLast;
   logic [7:0] setupLast;
   logic blocked;
   logic [11:0] modeMask;
   logic [11:0] roundedResult;
   logic [10:0] round10;
   logic [8:0] round8;
   logic [11:0] cmpValue;
   logic [12:0] cmpSum;
   logic cmpGe;
   logic cmpPass;
   logic doTransfer;
   logic singleCmpFail;
   logic [7:0] readMux;

   // Wishbone classic slave: one wait state, ack for one cycle per request.
   assign busTake = wb_cyc_i && wb_stb_i && !ackReg;
   assign busWrite = busTake && wb_we_i && wb_sel_i[0];
   assign busRead = busTake && !wb_we_i;
   assign wrCtrlOne = busWrite && (wb_adr_i == OFF_CTRL_ONE);
   assign wrModeChange = busWrite && ((wb_adr_i == OFF_CTRL_TWO) || (wb_adr_i == OFF_CONFIG)
                         || (wb_adr_i == OFF_CMP_HIGH) || (wb_adr_i == OFF_CMP_LOW));
   assign rdResHigh = busRead && (wb_adr_i == OFF_RES_HIGH);
   assign rdResLow = busRead && (wb_adr_i == OFF_RES_LOW);

   // Wait mode has no abort path, so conversions simply carry on in it.
   assign stopAbort = stopMode && (convCfg.inputClockSelect != CLK_ASYNC);
   assign abortAny = wrCtrlOne || wrModeChange || stopAbort;

   assign hwEdge = hwTriggerInput && !hwPrev;
   assign hwStart = ctrlTwo.triggerSelect && hwEdge && (state == ST_IDLE)
                    && (ctrlOne.channelSelect != CHANNEL_OFF);
   assign swStart = !ctrlTwo.triggerSelect && (wb_dat_i[4:0] != CHANNEL_OFF);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ackReg <= 1'b0;
         readData <= 32'h0;
      end else begin
         ackReg <= busTake;
         if (busRead) begin
            readData <= {24'h0, readMux};
         end
      end
   end

   assign wb_ack_o = ackReg;
   assign wb_dat_o = readData;

   always_comb begin
      readMux = 8'h00;
      case (wb_adr_i)
         OFF_CTRL_ONE: readMux = ctrlOne;
         OFF_CTRL_TWO: readMux = {(state != ST_IDLE), ctrlTwo.triggerSelect,
                                  ctrlTwo.compareEnable, ctrlTwo.compareGreaterSelect, 4'h0};
         OFF_CONFIG: readMux = convCfg;
         OFF_CMP_HIGH: readMux = cmpHigh;
         OFF_CMP_LOW: readMux = cmpLow;
         OFF_RES_HIGH: readMux = resultHigh;
         OFF_RES_LOW: readMux = resultLow;
         default: readMux = 8'h00;
      endcase
   end

   // Control one with the done flag; a completion wins over a clear in the same cycle.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlOne <= CTRL_ONE_RESET;
      end else begin
         if (wrCtrlOne) begin
            ctrlOne.doneIrqEnable <= wb_dat_i[6];
            ctrlOne.continuousEnable <= wb_dat_i[5];
            ctrlOne.channelSelect <= wb_dat_i[4:0];
         end
         if (doTransfer) begin
            ctrlOne.conversionDoneFlag <= 1'b1;
         end else if (wrCtrlOne || rdResLow) begin
            ctrlOne.conversionDoneFlag <= 1'b0;
         end
      end
   end

   assign doneIrq = ctrlOne.conversionDoneFlag && ctrlOne.doneIrqEnable;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlTwo <= CTRL_TWO_RESET;
         convCfg <= CONFIG_RESET;
         cmpHigh <= BYTE_RESET;
         cmpLow <= BYTE_RESET;
      end else if (busWrite) begin
         case (wb_adr_i)
            OFF_CTRL_TWO: ctrlTwo <= {1'b0, wb_dat_i[6:4], 4'h0};
            OFF_CONFIG: convCfg <= wb_dat_i[7:0];
            OFF_CMP_HIGH: cmpHigh <= wb_dat_i[7:0];
            OFF_CMP_LOW: cmpLow <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   // Outside 8-bit mode, a read of the high byte holds off transfers until the low byte has been read.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         readHighPending <= 1'b0;
      end else if (rdResHigh) begin
         readHighPending <= 1'b1;
      end else if (rdResLow) begin
         readHighPending <= 1'b0;
      end
   end

   assign blocked = readHighPending && (convCfg.mode != MODE_8BIT);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hwPrev <= 1'b0;
      end else begin
         hwPrev <= hwTriggerInput;
      end
   end

   // Conversion clock ticks; the internal half-rate and asynchronous sources and the divider stop while idle.
   always_comb begin
      case (convCfg.inputClockSelect)
         CLK_BUS: srcTick = 1'b1;
         CLK_BUS_HALF: srcTick = halfPhase;
         CLK_ALT: srcTick = altClockTick;
         default: srcTick = (asyncCnt == ASYNC_DIV_LAST);
      endcase
      case (convCfg.clockDivider)
         2'h0: divLast = 3'h0;
         2'h1: divLast = 3'h1;
         2'h2: divLast = 3'h3;
         default: divLast = 3'h7;
      endcase
   end

   assign adckTick = srcTick && (divCnt == divLast);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         halfPhase <= 1'b0;
         asyncCnt <= 2'h0;
         divCnt <= 3'h0;
      end else if (state == ST_IDLE) begin
         halfPhase <= 1'b0;
         asyncCnt <= 2'h0;
         divCnt <= 3'h0;
      end else begin
         halfPhase <= !halfPhase;
         asyncCnt <= (asyncCnt == ASYNC_DIV_LAST) ? 2'h0 : asyncCnt + 2'h1;
         if (srcTick) begin
            divCnt <= (divCnt == divLast) ? 3'h0 : divCnt + 3'h1;
         end
      end
   end

   // First conversions carry three extra ticks and the bus-cycle startup.
   assign sampleLast = 5'((convCfg.longSampleSelect ? SAMPLE_LONG_TICKS : SAMPLE_SHORT_TICKS)
                       + (firstConv ? FIRST_EXTRA_TICKS : 5'h00) - 5'h01);
   assign approxLast = 5'(((convCfg.mode == MODE_8BIT) ? APPROX_8BIT_TICKS : APPROX_WIDE_TICKS)
                       - 5'h01);
   assign setupLast = (convCfg.inputClockSelect == CLK_ASYNC) ? SETUP_ASYNC_LAST
                                                              : SETUP_SYNC_LAST;

   // Result rounding, compare arithmetic and the transfer decision.
   assign round10 = {1'b0, approxResult[11:2]} + {10'h0, approxResult[1]};
   assign round8 = {1'b0, approxResult[11:4]} + {8'h0, approxResult[3]};

   always_comb begin
      case (convCfg.mode)
         MODE_10BIT: begin
            modeMask = MASK_10BIT;
            roundedResult = round10[10] ? MASK_10BIT : {2'h0, round10[9:0]};
         end
         MODE_8BIT: begin
            modeMask = MASK_8BIT;
            roundedResult = round8[8] ? MASK_8BIT : {4'h0, round8[7:0]};
         end
         default: begin
            modeMask = MASK_12BIT;
            roundedResult = approxResult;
         end
      endcase
   end

   assign cmpValue = {cmpHigh[3:0], cmpLow} & modeMask;
   assign cmpSum = {1'b0, roundedResult} + {1'b0, ~cmpValue} + 13'h0001;
   assign cmpGe = cmpSum[12];
   assign cmpPass = !ctrlTwo.compareEnable
                    || (ctrlTwo.compareGreaterSelect ? cmpGe : !cmpGe);
   assign doTransfer = (state == ST_TRANSFER) && !abortAny && !blocked && cmpPass;
   assign singleCmpFail = !ctrlOne.continuousEnable && ctrlTwo.compareEnable && !cmpPass;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         resultHigh <= BYTE_RESET;
         resultLow <= BYTE_RESET;
      end else if (doTransfer) begin
         if (ctrlTwo.compareEnable) begin
            resultHigh <= {4'h0, cmpSum[11:8] & modeMask[11:8]};
            resultLow <= cmpSum[7:0];
         end else begin
            resultHigh <= {4'h0, roundedResult[11:8]};
            resultLow <= roundedResult[7:0];
         end
      end
   end

   // Sequencer: aborts first, then starts, then the conversion phases.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         firstConv <= 1'b0;
         busCnt <= 8'h00;
         tickCnt <= 5'h00;
      end else if (wrCtrlOne && !stopAbort) begin
         busCnt <= 8'h00;
         tickCnt <= 5'h00;
         firstConv <= 1'b1;
         state <= swStart ? ST_SETUP : ST_IDLE;
      end else if (abortAny) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (hwStart) begin
                  busCnt <= 8'h00;
                  tickCnt <= 5'h00;
                  firstConv <= 1'b1;
                  state <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               busCnt <= busCnt + 8'h01;
               if (busCnt == setupLast) begin
                  state <= ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               if (adckTick) begin
                  tickCnt <= (tickCnt == sampleLast) ? 5'h00 : tickCnt + 5'h01;
                  if (tickCnt == sampleLast) begin
                     state <= ST_APPROX;
                  end
               end
            end
            ST_APPROX: begin
               if (adckTick) begin
                  tickCnt <= (tickCnt == approxLast) ? 5'h00 : tickCnt + 5'h01;
                  if (tickCnt == approxLast) begin
                     state <= ST_TRANSFER;
                  end
               end
            end
            ST_TRANSFER: begin
               firstConv <= 1'b0;
               tickCnt <= 5'h00;
               if (blocked) begin
                  state <= singleCmpFail ? ST_IDLE : ST_SAMPLE;
               end else begin
                  state <= ctrlOne.continuousEnable ? ST_SAMPLE : ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // One assignment drives the whole struct so that it has a single driver.
   assign analogCtrl = {ctrlOne.channelSelect, (state == ST_SAMPLE),
                        (state != ST_IDLE) && (convCfg.inputClockSelect == CLK_ASYNC),
                        convCfg.lowPowerConfig};

   // Checks on the sequencer.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence sampleEnds;
      (state == ST_SAMPLE) ##1 (state == ST_APPROX);
   endsequence

   chk_sw_start: assert property (
      wrCtrlOne && swStart && !stopAbort |=> state == ST_SETUP)
      else $error("software write did not start a conversion");

   chk_hw_start: assert property (
      hwStart && !abortAny |=> state == ST_SETUP)
      else $error("trigger edge did not start a conversion");

   chk_cont_restart: assert property (
      doTransfer && ctrlOne.continuousEnable |=> state == ST_SAMPLE)
      else $error("continuous mode did not restart");

   chk_done_cause: assert property (
      $rose(ctrlOne.conversionDoneFlag) |-> $past(state == ST_TRANSFER) && $past(doTransfer))
      else $error("done flag set without a transfer");

   chk_block_drop: assert property (
      (state == ST_TRANSFER) && blocked && !ctrlOne.conversionDoneFlag
      |=> !ctrlOne.conversionDoneFlag && $stable(resultLow) && $stable(resultHigh))
      else $error("blocked transfer changed the result");

   chk_block_restart: assert property (
      (state == ST_TRANSFER) && blocked && !abortAny && !singleCmpFail |=> state == ST_SAMPLE)
      else $error("blocked transfer did not convert again");

   chk_mode_abort: assert property (
      wrModeChange && !wrCtrlOne |=> (state == ST_IDLE) ##1 ((state == ST_IDLE) || $past(hwStart)))
      else $error("mode write did not abort");

   chk_stop_abort: assert property (
      stopAbort |=> state == ST_IDLE)
      else $error("stop entry did not abort");

   chk_idle_quiet: assert property (
      (state == ST_IDLE) |-> !analogCtrl.sampleEnable && !analogCtrl.asyncClockEnable)
      else $error("idle converter is active");

   chk_sample_len: assert property (
      sampleEnds |-> $past(tickCnt) == $past(sampleLast))
      else $error("sample phase length wrong");

   chk_setup_len: assert property (
      (state == ST_SETUP) && (busCnt == 8'h00) && (setupLast == SETUP_SYNC_LAST) && !abortAny
      |=> (state == ST_SETUP) [*4] ##1 (state == ST_SAMPLE) || (state == ST_IDLE))
      else $error("startup bus cycles wrong");

   chk_compare_false: assert property (
      (state == ST_TRANSFER) && !cmpPass |=> $stable(resultLow) && $stable(resultHigh))
      else $error("failed compare transferred data");

   chk_disabled_idle: assert property (
      (ctrlOne.channelSelect == CHANNEL_OFF) |-> state == ST_IDLE)
      else $error("converter running with channel off");

   chk_trigger_ignored: assert property (
      (state inside {ST_SAMPLE, ST_APPROX, ST_TRANSFER}) && hwEdge && !abortAny
      |=> state != ST_SETUP)
      else $error("trigger edge restarted a running conversion");

   chk_wait_runs: assert property (
      waitMode && (state inside {ST_SAMPLE, ST_APPROX}) && !abortAny |=> state != ST_IDLE)
      else $error("wait mode stopped a conversion");

endmodule // adc_conversion_sequencer

/* adc_analog_model.sv */
// Analog input array and trigger source facing the conversion sequencer.
`timescale 1ns/10ps
module adc_analog_model
   import adc_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire analog_ctrl_t analogCtrl,
   input wire logic [11:0] level,
   input wire logic fire,
   output logic [11:0] approxResult,
   output logic hwTriggerInput,
   output logic altClockTick
);
   logic [1:0] tickCnt;
   // A deselected input floats, so the array then returns a wrong value.
   assign approxResult = (analogCtrl.channel == CHANNEL_OFF) ? ~level : level;
   assign altClockTick = (tickCnt == 2'h2);
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tickCnt <= 2'h0;
         hwTriggerInput <= 1'b0;
      end else begin
         tickCnt <= (tickCnt == 2'h2) ? 2'h0 : tickCnt + 2'h1;
         hwTriggerInput <= fire;
      end
   end
endmodule // adc_analog_model

/* adc_conversion_sequencer_tb_top.sv */
// Self-checking bench for the conversion sequencer.
`timescale 1ns/10ps
module adc_conversion_sequencer_tb_top;
   import adc_seq_pkg::*;
   localparam logic [7:0] RST [8] = '{8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] CFG [5] = '{8'h00, 8'h04, 8'h18, 8'h06, 8'h07};
   localparam logic [11:0] LVL [5] = '{12'ha50, 12'h123, 12'h5a4, 12'h7ff, 12'h801};
   localparam logic [7:0] HI [5] = '{8'h00, 8'h01, 8'h01, 8'h07, 8'h08};
   localparam logic [7:0] LO [5] = '{8'ha5, 8'h23, 8'h69, 8'hff, 8'h01};
   localparam int LIM [5] = '{25, 28, 48, 77, 253};
   localparam logic [7:0] ABA [5] = '{OFF_CTRL_TWO, OFF_CONFIG, OFF_CMP_HIGH, OFF_CMP_LOW,
      OFF_CTRL_ONE};
   localparam logic [7:0] ABD [5] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h5f};
   logic core_clk, reset_n, cyc, stb, we, fire, stopMode, waitMode, doneIrq, ack, hwTrig, alt;
   logic [7:0] adr;
   logic [31:0] datI, datO;
   logic [11:0] level, approx;
   analog_ctrl_t ctrl;
   int error_cnt = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;
   adc_conversion_sequencer DUT (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(datI),
      .wb_dat_o(datO), .wb_ack_o(ack), .hwTriggerInput(hwTrig), .altClockTick(alt),
      .approxResult(approx), .stopMode(stopMode), .waitMode(waitMode), .analogCtrl(ctrl),
      .doneIrq(doneIrq));
   adc_analog_model model (.core_clk(core_clk), .reset_n(reset_n), .analogCtrl(ctrl),
      .level(level), .fire(fire), .approxResult(approx), .hwTriggerInput(hwTrig),
      .altClockTick(alt));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datI <= {24'h0, d};
      @(posedge core_clk);
      while (ack !== 1'b1) @(posedge core_clk);
      q = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      check(q, {24'h0, e});
   endtask
   // Waits for the completion interrupt and checks it came within the bound.
   task automatic waitIrq(input int bound);
      n = 0;
      while (doneIrq !== 1'b1 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      check(n <= bound, 1'b1);
   endtask
   initial begin
      reset_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      datI = 32'h0;
      level = 12'h123;
      fire = 1'b0;
      stopMode = 1'b0;
      waitMode = 1'b0;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      check(ctrl, {CHANNEL_OFF, 3'h0});
      for (int i = 0; i < 8; i++) rd(8'(4 * i), RST[i]);
      for (int i = 0; i < 5; i++) begin
         level <= LVL[i];
         wr(OFF_CONFIG, CFG[i]);
         wr(OFF_CTRL_ONE, 8'h41);
         check(ctrl.asyncClockEnable, CFG[i][1:0] == CLK_ASYNC);
         waitIrq(LIM[i]);
         rd(OFF_RES_HIGH, HI[i]);
         rd(OFF_RES_LOW, LO[i]);
         check({ctrl.sampleEnable, ctrl.asyncClockEnable, doneIrq}, 3'h0);
      end
      wr(OFF_CONFIG, 8'h04);
      wr(OFF_CTRL_ONE, 8'h41);
      // Reading the high byte mid-conversion arms the overwrite guard.
      rd(OFF_RES_HIGH, 8'h08);
      level <= 12'h7e1;
      repeat (60) @(posedge core_clk);
      check(doneIrq, 1'b0);
      rd(OFF_CTRL_TWO, 8'h80);
      rd(OFF_RES_LOW, 8'h01);
      waitIrq(60);
      rd(OFF_RES_HIGH, 8'h07);
      rd(OFF_RES_LOW, 8'he1);
      level <= 12'h456;
      for (int i = 0; i < 6; i++) begin
         wr(OFF_CTRL_ONE, 8'h41);
         repeat (8) @(posedge core_clk);
         if (i == 5) begin
            stopMode <= 1'b1;
         end else begin
            wr(ABA[i], ABD[i]);
         end
         repeat (60) @(posedge core_clk);
         stopMode <= 1'b0;
         check(doneIrq, 1'b0);
         rd(OFF_CTRL_TWO, 8'h00);
         rd(OFF_RES_LOW, 8'he1);
      end
      wr(OFF_CTRL_TWO, 8'h40);
      wr(OFF_CTRL_ONE, 8'h41);
      repeat (40) @(posedge core_clk);
      check(doneIrq, 1'b0);
      fire <= 1'b1;
      repeat (4) @(posedge core_clk);
      fire <= 1'b0;
      waitIrq(28);
      rd(OFF_RES_LOW, 8'h56);
      wr(OFF_CTRL_TWO, 8'h00);
      waitMode <= 1'b1;
      wr(OFF_CTRL_ONE, 8'h61);
      waitIrq(28);
      rd(OFF_RES_LOW, 8'h56);
      level <= 12'h9ab;
      // A trigger edge in mid-conversion must not restart it.
      fire <= 1'b1;
      waitIrq(20);
      rd(OFF_RES_LOW, 8'hab);
      wr(OFF_CTRL_ONE, 8'h1f);
      waitMode <= 1'b0;
      fire <= 1'b0;
      wr(OFF_CTRL_TWO, 8'h30);
      wr(OFF_CMP_HIGH, 8'h01);
      wr(OFF_CMP_LOW, 8'h00);
      level <= 12'h180;
      wr(OFF_CTRL_ONE, 8'h41);
      waitIrq(28);
      rd(OFF_RES_HIGH, 8'h00);
      rd(OFF_RES_LOW, 8'h80);
      level <= 12'h0ff;
      wr(OFF_CTRL_ONE, 8'h41);
      repeat (80) @(posedge core_clk);
      check(doneIrq, 1'b0);
      rd(OFF_CTRL_TWO, 8'h30);
      rd(OFF_RES_LOW, 8'h80);
      wr(OFF_CTRL_TWO, 8'h20);
      wr(OFF_CTRL_ONE, 8'h41);
      waitIrq(28);
      rd(OFF_RES_HIGH, 8'h0f);
      wr(OFF_CTRL_ONE, 8'h41);
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      rd(OFF_RES_HIGH, 8'h00);
      rd(OFF_RES_LOW, 8'h00);
      wrap_up();
   end
endmodule // adc_conversion_sequencer_tb_top
